/* logic/aksr_pkg.sv */
// shared constants and types of the aes key source register bank
package aksr_pkg;
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int BW = 4;
  localparam int KW = 128;
  localparam int NWORD = 4;
  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [AW-1:0] OFS_ENABLE = 16'h0500;
  localparam logic [AW-1:0] OFS_KSEL = 16'h1A38;
  localparam logic [AW-1:0] OFS_LOCK = 16'h1A4C;
  localparam logic [AW-1:0] OFS_KEY0 = 16'h1A50;
  localparam logic [AW-1:0] OFS_KEY1 = 16'h1A54;
  localparam logic [AW-1:0] OFS_KEY2 = 16'h1A58;
  localparam logic [AW-1:0] OFS_KEY3 = 16'h1A5C;
  localparam logic [AW-1:0] OFS_LCS = 16'h1A60;
  // ******************************
  // field positions and reset values
  // ******************************
  localparam int EN_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int VALID_BIT = 0;
  localparam int KSEL_LSB = 0;
  localparam int KSEL_W = 2;
  localparam int LCS_LSB = 0;
  localparam int LCS_W = 3;
  localparam logic EN_RST = 1'h0;
  localparam logic [KSEL_W-1:0] KSEL_RST = 2'h0;
  localparam logic [LCS_W-1:0] LCS_RST = 3'h0;
  localparam logic [DW-1:0] RD_ZERO = 32'h00000000;
  localparam logic [BW-1:0] BE_ALL = 4'hF;
  // ******************************
  // enumerations
  // ******************************
  typedef enum logic [1:0] {
    KSEL_ROOT = 2'h0,
    KSEL_FIXED = 2'h1,
    KSEL_SESSION = 2'h2,
    KSEL_NONE = 2'h3
  } aksr_ksel_t;
  typedef enum logic [2:0] {
    LCS_DEBUG = 3'h0,
    LCS_SECURE = 3'h2
  } aksr_lcs_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } aksr_bus_st_t;
  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic read;
    logic write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [BW-1:0] byteenable;
  } aksr_av_req_t;
  typedef struct packed {
    logic lock_set;
    logic [NWORD-1:0] word_we;
    logic [DW-1:0] wdata;
    logic [BW-1:0] be;
  } aksr_ao_wr_t;
  // byte-lane merge of a write into a stored word
  function automatic logic [DW-1:0] bemerge(input logic [DW-1:0] old_w,
                                            input logic [DW-1:0] new_w,
                                            input logic [BW-1:0] be);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < BW; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

/* logic/aksr_ao_store.sv */
// always-on storage of the fixed-key lock and the device root key
`timescale 1ns/1ns
module aksr_ao_store
  import aksr_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic ao_rst_b, // always-on reset, active low
  input aksr_ao_wr_t wr, // gated write request
  output logic lock, // fixed-key lock
  output logic [KW-1:0] root_key, // device root key
  output logic [NWORD-1:0] written // word written flags
);
  logic lock_reg, lock_next;
  logic [KW-1:0] key_reg, key_next;
  logic [NWORD-1:0] wr_reg, wr_next;

  assign lock_next = lock_reg | wr.lock_set;
  assign wr_next = wr_reg | wr.word_we;

  // word i holds key bits 32i+31:32i
  always_comb begin
    key_next = key_reg;
    for (int i = 0; i < NWORD; i++) begin
      if (wr.word_we[i]) begin
        key_next[i*DW +: DW] = bemerge(key_reg[i*DW +: DW], wr.wdata, wr.be);
      end
    end
  end

  // only the always-on reset clears this state
  always_ff @(posedge core_clk) begin
    if (!ao_rst_b) begin
      lock_reg <= 1'b0;
      key_reg <= '0;
      wr_reg <= '0;
    end else begin
      lock_reg <= lock_next;
      key_reg <= key_next;
      wr_reg <= wr_next;
    end
  end

  assign lock = lock_reg;
  assign root_key = key_reg;
  assign written = wr_reg;
endmodule

/* logic/aksr_key_mux.sv */
// selection of the hardware key presented to the aes engine
`timescale 1ns/1ns
module aksr_key_mux
  import aksr_pkg::*;
#(
  // arbitrary value, stands in for the hard-coded design key
  parameter logic [KW-1:0] FIXED_KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
)(
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic en, // subsystem enable
  input wire logic [KSEL_W-1:0] sel, // key source select
  input wire logic lock, // fixed-key lock
  input wire logic [KW-1:0] root_key, // device root key
  input wire logic [KW-1:0] session_key, // session key
  output logic [KW-1:0] hw_key, // key to aes engine
  output logic hw_key_valid // key usable
);
  logic [KW-1:0] key_reg, key_next;
  logic vld_reg;
  wire [KW-1:0] fixed_sel;

  // a locked fixed key reads as zero
  assign fixed_sel = lock ? '0 : FIXED_KEY;

  always_comb begin
    case (sel)
      KSEL_ROOT: key_next = root_key;
      KSEL_FIXED: key_next = fixed_sel;
      KSEL_SESSION: key_next = session_key;
      default: key_next = '0;
    endcase
    if (!en) begin
      key_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      key_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      key_reg <= key_next;
      vld_reg <= en;
    end
  end

  assign hw_key = key_reg;
  assign hw_key_valid = vld_reg;
endmodule

/* logic/aksr_regs.sv */
// register bank for enable, aes key source and root key storage
`timescale 1ns/1ns
module aksr_regs
  import aksr_pkg::*;
#(
  parameter logic [KW-1:0] FIXED_KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
)(
  input wire logic core_clk, // 100 MHz clock
  input wire logic rst_b, // bus reset, active low
  input wire logic ao_rst_b, // always-on reset, active low
  input aksr_av_req_t av_req, // avalon request
  output logic [DW-1:0] av_readdata, // avalon read data
  output logic av_waitrequest, // avalon wait
  input wire logic [KW-1:0] session_key, // session key
  output logic [KW-1:0] aes_hw_key, // key to aes engine
  output logic aes_key_valid, // key usable
  output logic subsystem_en, // subsystem enabled
  output logic [LCS_W-1:0] lifecycle_state // lifecycle state
);

  // ******************************
  // bus handshake
  // ******************************

  aksr_bus_st_t st_reg, st_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  wire req;
  wire wr_go;
  wire rd_go;

  assign req = av_req.read | av_req.write;
  // one wait cycle, then the request is taken
  assign av_waitrequest = req & (st_reg == BUS_IDLE);
  assign wr_go = av_req.write & (st_reg == BUS_DONE);
  assign rd_go = av_req.read & (st_reg == BUS_DONE);

  always_comb begin
    case (st_reg)
      BUS_IDLE: st_next = req ? BUS_DONE : BUS_IDLE;
      BUS_DONE: st_next = BUS_IDLE;
      default: st_next = BUS_IDLE;
    endcase
  end

  // ******************************
  // address decode
  // ******************************

  wire hit_en;
  wire hit_sel;
  wire hit_lock;
  wire hit_lcs;
  wire [NWORD-1:0] hit_key;

  assign hit_en = av_req.address == OFS_ENABLE;
  assign hit_sel = av_req.address == OFS_KSEL;
  assign hit_lock = av_req.address == OFS_LOCK;
  assign hit_lcs = av_req.address == OFS_LCS;
  assign hit_key[0] = av_req.address == OFS_KEY0;
  assign hit_key[1] = av_req.address == OFS_KEY1;
  assign hit_key[2] = av_req.address == OFS_KEY2;
  assign hit_key[3] = av_req.address == OFS_KEY3;

  // ******************************
  // control registers
  // ******************************

  logic en_reg, en_next;
  logic [KSEL_W-1:0] sel_reg, sel_next;
  logic [LCS_W-1:0] lcs_reg, lcs_next;
  wire [DW-1:0] en_word;
  wire [DW-1:0] sel_word;
  wire [DW-1:0] lcs_word;
  wire cfg_go;
  wire [DW-1:0] en_merge;
  wire [DW-1:0] sel_merge;
  wire [DW-1:0] lcs_merge;

  assign en_word = {{(DW-1){1'b0}}, en_reg};
  assign sel_word = {{(DW-KSEL_W){1'b0}}, sel_reg};
  assign lcs_word = {{(DW-LCS_W){1'b0}}, lcs_reg};

  // crypto settings are written only while enabled
  assign cfg_go = wr_go & en_reg;

  assign en_merge = bemerge(en_word, av_req.writedata, av_req.byteenable);
  assign sel_merge = bemerge(sel_word, av_req.writedata, av_req.byteenable);
  assign lcs_merge = bemerge(lcs_word, av_req.writedata, av_req.byteenable);

  // enable bit steers the whole subsystem
  assign en_next = (wr_go & hit_en) ? en_merge[EN_BIT] : en_reg;
  assign sel_next = (cfg_go & hit_sel) ? sel_merge[KSEL_LSB +: KSEL_W] : sel_reg;
  assign lcs_next = (cfg_go & hit_lcs) ? lcs_merge[LCS_LSB +: LCS_W] : lcs_reg;

  // subsystem starts disabled with the root key selected
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= BUS_IDLE;
      rdata_reg <= RD_ZERO;
      en_reg <= EN_RST;
      sel_reg <= KSEL_RST;
      lcs_reg <= LCS_RST;
    end else begin
      st_reg <= st_next;
      rdata_reg <= rdata_next;
      en_reg <= en_next;
      sel_reg <= sel_next;
      lcs_reg <= lcs_next;
    end
  end

  // ******************************
  // always-on store
  // ******************************

  aksr_ao_wr_t ao_wr;
  logic ao_lock;
  logic [KW-1:0] root_key;
  logic [NWORD-1:0] written;
  wire secure;
  wire key_valid;
  wire [NWORD-1:0] key_ok;

  assign secure = lcs_reg != LCS_DEBUG;
  assign key_valid = &written;
  // a word already written is frozen outside debug state
  assign key_ok = secure ? ~written : {NWORD{1'b1}};

  // only a write of one sets the lock
  assign ao_wr.lock_set = cfg_go & hit_lock & av_req.byteenable[0] &
                          av_req.writedata[LOCK_BIT];
  // word strobes to the always-on store
  assign ao_wr.word_we = {NWORD{cfg_go}} & hit_key & key_ok;
  assign ao_wr.wdata = av_req.writedata;
  assign ao_wr.be = av_req.byteenable;

  // lock and root key kept in the always-on domain
  aksr_ao_store aksr_ao_store_i (
    .core_clk(core_clk),
    .ao_rst_b(ao_rst_b),
    .wr(ao_wr),
    .lock(ao_lock),
    .root_key(root_key),
    .written(written)
  );

  // ******************************
  // read data
  // ******************************

  wire [DW-1:0] lock_word;
  wire [DW-1:0] status_word;

  assign lock_word = {{(DW-1){1'b0}}, ao_lock};
  // word 0 reads as retention status, key words never read back
  assign status_word = {{(DW-1){1'b0}}, key_valid};

  always_comb begin
    rdata_next = rdata_reg;
    if (av_req.read && st_reg == BUS_IDLE) begin
      if (hit_en) begin
        rdata_next = en_word;
      end else if (hit_sel) begin
        rdata_next = sel_word;
      end else if (hit_lock) begin
        rdata_next = lock_word;
      end else if (hit_key[0]) begin
        rdata_next = status_word;
      end else if (hit_lcs) begin
        rdata_next = lcs_word;
      end else begin
        rdata_next = RD_ZERO;
      end
    end
  end

  assign av_readdata = rdata_reg;

  // ******************************
  // key routing
  // ******************************

  // select code picks the engine key source
  aksr_key_mux #(
    .FIXED_KEY(FIXED_KEY)
  ) aksr_key_mux_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .en(en_reg),
    .sel(sel_reg),
    .lock(ao_lock),
    .root_key(root_key),
    .session_key(session_key),
    .hw_key(aes_hw_key),
    .hw_key_valid(aes_key_valid)
  );

  assign subsystem_en = en_reg;
  assign lifecycle_state = lcs_reg;

  // ******************************
  // checks
  // ******************************

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_root_route: assert property (
    en_reg && sel_reg == KSEL_ROOT |=> aes_hw_key == $past(root_key))
    else $error("root key not routed");

  chk_session_route: assert property (
    en_reg && sel_reg == KSEL_SESSION |=> aes_hw_key == $past(session_key))
    else $error("session key not routed");

  chk_fixed_zeroed: assert property (
    en_reg && sel_reg == KSEL_FIXED && ao_lock |=> aes_hw_key == '0)
    else $error("locked fixed key reached engine");

  chk_lock_sticky: assert property (
    ao_lock ##1 ao_rst_b |-> ao_lock)
    else $error("lock released by write");

  chk_lock_set_once: assert property (
    ao_wr.lock_set && ao_rst_b ##1 ao_rst_b [*3] |-> ao_lock)
    else $error("lock not held after set");

  chk_word0_write: assert property (
    ao_wr.word_we[0] && av_req.byteenable == BE_ALL ##1 ao_rst_b
      |-> root_key[31:0] == $past(av_req.writedata))
    else $error("key bits 31:0 not stored");

  chk_word0_status: assert property (
    rd_go && hit_key[0] |-> av_readdata == status_word)
    else $error("word 0 read is not status");

  chk_word3_write: assert property (
    ao_wr.word_we[3] && av_req.byteenable == BE_ALL ##1 ao_rst_b
      |-> root_key[127:96] == $past(av_req.writedata))
    else $error("key bits 127:96 not stored");

  chk_ao_retain: assert property (
    @(posedge core_clk) disable iff (!ao_rst_b)
    !rst_b |=> $stable(root_key) && $stable(ao_lock))
    else $error("always-on state lost in bus reset");

  chk_lcs_read: assert property (
    rd_go && hit_lcs |-> av_readdata == lcs_word)
    else $error("lifecycle read mismatch");

  chk_secure_once: assert property (
    secure && written[2] ##1 ao_rst_b |-> $stable(root_key[95:64]))
    else $error("secure key word rewritten");

  chk_disabled_key: assert property (
    !en_reg |=> aes_hw_key == '0 && !aes_key_valid)
    else $error("key present while disabled");

  chk_disabled_cfg: assert property (
    !en_reg |=> $stable(sel_reg) && $stable(lcs_reg))
    else $error("config changed while disabled");

  chk_reset_vals: assert property (
    $past(!rst_b) |-> !en_reg && sel_reg == KSEL_ROOT)
    else $error("reset values wrong");

  chk_bus_wait: assert property (
    req && st_reg == BUS_IDLE |-> av_waitrequest ##1 !av_waitrequest)
    else $error("wait not exactly one cycle");

  chk_fixed_route: assert property (
    en_reg && sel_reg == KSEL_FIXED && !ao_lock |=> aes_hw_key == FIXED_KEY)
    else $error("fixed key not routed");

  chk_select_write: assert property (
    cfg_go && hit_sel && av_req.byteenable[0]
      |=> sel_reg == $past(av_req.writedata[KSEL_LSB +: KSEL_W]))
    else $error("key select write lost");

  chk_select_three: assert property (
    en_reg && sel_reg == KSEL_NONE |=> aes_hw_key == '0)
    else $error("unused select gave a key");

  chk_lock_zero_write: assert property (
    wr_go && hit_lock && !av_req.writedata[LOCK_BIT] && !ao_lock && ao_rst_b |=> !ao_lock)
    else $error("lock set by a zero write");

  chk_lock_bus_reset: assert property (
    @(posedge core_clk) disable iff (!ao_rst_b)
    ao_lock |=> ao_lock)
    else $error("lock lost in bus reset");

  chk_word1_write: assert property (
    ao_wr.word_we[1] && av_req.byteenable == BE_ALL ##1 ao_rst_b
      |-> root_key[63:32] == $past(av_req.writedata))
    else $error("key bits 63:32 not stored");

  chk_word2_write: assert property (
    ao_wr.word_we[2] && av_req.byteenable == BE_ALL ##1 ao_rst_b
      |-> root_key[95:64] == $past(av_req.writedata))
    else $error("key bits 95:64 not stored");

  chk_key_reads_zero: assert property (
    rd_go && (|hit_key[NWORD-1:1]) |-> av_readdata == RD_ZERO)
    else $error("key word read back");

  chk_lcs_write: assert property (
    cfg_go && hit_lcs && av_req.byteenable[0]
      |=> lcs_reg == $past(av_req.writedata[LCS_LSB +: LCS_W]))
    else $error("lifecycle write lost");

  chk_enable_write: assert property (
    wr_go && hit_en && av_req.byteenable[0] |=> en_reg == $past(av_req.writedata[EN_BIT]))
    else $error("enable write lost");

  chk_valid_follows: assert property (
    en_reg |=> aes_key_valid)
    else $error("key not valid while enabled");

  cov_bus_reset_kept: cover property (
    @(posedge core_clk) disable iff (!ao_rst_b)
    !rst_b ##1 rst_b && key_valid);

  cov_key_retained: cover property (
    !key_valid ##1 key_valid);

  cov_lock_fixed: cover property (
    en_reg && sel_reg == KSEL_FIXED && ao_lock);

  cov_session_use: cover property (
    en_reg && sel_reg == KSEL_SESSION ##1 aes_key_valid);

  cov_secure_refused: cover property (
    cfg_go && secure && |(hit_key & written));

endmodule

/* verif/aksr_regs_tb.sv */
// self-checking bench of the aes key source register bank
`timescale 1ns/1ns
module aksr_regs_tb;
  import aksr_pkg::*;
  // ******************************
  // stimulus, clock and instance
  // ******************************
  // arbitrary stand-in values
  localparam logic [KW-1:0] FK = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [KW-1:0] SK = 128'hA5A5A5A5C3C3C3C3F0F0F0F01E1E1E1E;
  localparam logic [DW-1:0] KWD [NWORD] = '{32'h11111111, 32'h2222ABCD, 32'h33333333,
                                            32'h44444444};
  localparam logic [AW-1:0] KADR [NWORD] = '{OFS_KEY0, OFS_KEY1, OFS_KEY2, OFS_KEY3};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ao_rst_b = 1'b0;
  aksr_av_req_t av_req = '0;
  logic [KW-1:0] session_key = SK;
  logic [DW-1:0] av_readdata;
  logic av_waitrequest;
  logic [KW-1:0] aes_hw_key;
  logic aes_key_valid;
  logic subsystem_en;
  logic [LCS_W-1:0] lifecycle_state;
  logic [KW-1:0] rk;
  int errors = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;

  aksr_regs #(.FIXED_KEY(FK)) aksr_regs_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ao_rst_b(ao_rst_b),
    .av_req(av_req),
    .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest),
    .session_key(session_key),
    .aes_hw_key(aes_hw_key),
    .aes_key_valid(aes_key_valid),
    .subsystem_en(subsystem_en),
    .lifecycle_state(lifecycle_state)
  );

  // ******************************
  // tasks
  // ******************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [KW-1:0] seen, input logic [KW-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon access; entered just after a rising edge, returns just after one
  task automatic bus(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] d,
                     input logic [BW-1:0] be, output logic [DW-1:0] q);
    int n;
    logic wt;
    n = 0;
    wt = 1'b1;
    av_req.read <= rd;
    av_req.write <= ~rd;
    av_req.address <= a;
    av_req.writedata <= d;
    av_req.byteenable <= be;
    do begin
      @(posedge core_clk);
      wt = av_waitrequest;
      q = av_readdata;
      n++;
    end while (wt && n < 100);
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    if (wt) begin
      errors++;
      wrap_up();
    end else begin
      @(posedge core_clk);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input logic [BW-1:0] be = BE_ALL);
    logic [DW-1:0] q;
    bus(1'b0, a, d, be, q);
  endtask

  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] q;
    bus(1'b1, a, RD_ZERO, BE_ALL, q);
    check(nm, {96'h0, q}, {96'h0, e});
  endtask

  // key output lags its sources by one registered stage
  task automatic kchk(input string nm, input logic [KW-1:0] e);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(nm, aes_hw_key, e);
    @(posedge core_clk);
  endtask

  task automatic pchk(input string nm, input logic [KW-1:0] seen, input logic [KW-1:0] e);
    @(negedge core_clk);
    check(nm, seen, e);
    @(posedge core_clk);
  endtask

  task automatic do_reset(input logic ao);
    rst_b <= 1'b0;
    ao_rst_b <= ~ao;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    ao_rst_b <= 1'b1;
    @(posedge core_clk);
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    do_reset(1'b1);
    pchk("subsystem_en", {127'h0, subsystem_en}, '0);
    pchk("aes_key_valid", {127'h0, aes_key_valid}, '0);
    pchk("aes_hw_key", aes_hw_key, '0);
    rchk("enable", OFS_ENABLE, 32'h0);
    rchk("key_select", OFS_KSEL, 32'h0);
    rchk("lifecycle", OFS_LCS, 32'h0);
    rchk("key_status", OFS_KEY0, 32'h0);
    rchk("lock", OFS_LOCK, 32'h0);
    // configuration is ignored while disabled
    wr(OFS_KSEL, 32'h2);
    rchk("key_select_off", OFS_KSEL, 32'h0);
    wr(OFS_ENABLE, 32'h1);
    rchk("enable_on", OFS_ENABLE, 32'h1);
    pchk("subsystem_en_on", {127'h0, subsystem_en}, 128'h1);
    pchk("aes_key_valid_on", {127'h0, aes_key_valid}, 128'h1);
    for (int i = 0; i < NWORD; i++) begin
      rchk("key_status_partial", OFS_KEY0, 32'h0);
      wr(KADR[i], KWD[i]);
    end
    rk = {KWD[3], KWD[2], KWD[1], KWD[0]};
    rchk("key_status_full", OFS_KEY0, 32'h1);
    rchk("key_word1_read", OFS_KEY1, 32'h0);
    kchk("root_key", rk);
    // debug state allows rewriting, byte lanes honoured
    wr(OFS_KEY1, 32'hFFFFFFFF, 4'h3);
    rk[63:32] = {KWD[1][31:16], 16'hFFFF};
    kchk("root_key_rewrite", rk);
    wr(OFS_KSEL, 32'h1);
    kchk("fixed_key", FK);
    wr(OFS_KSEL, 32'h2);
    session_key <= ~SK;
    kchk("session_key", ~SK);
    wr(OFS_KSEL, 32'h3);
    kchk("select_three", '0);
    wr(OFS_KSEL, 32'h1);
    wr(OFS_LOCK, 32'h0);
    kchk("lock_zero_write", FK);
    wr(OFS_LOCK, 32'h1);
    kchk("locked_fixed", '0);
    rchk("lock_set", OFS_LOCK, 32'h1);
    wr(OFS_LOCK, 32'h0);
    rchk("lock_kept", OFS_LOCK, 32'h1);
    kchk("locked_still", '0);
    wr(16'h1A64, 32'hFFFFFFFF);
    rchk("unmapped", 16'h1A64, 32'h0);
    // bus reset keeps the always-on contents
    do_reset(1'b0);
    rchk("enable_bus_reset", OFS_ENABLE, 32'h0);
    rchk("status_kept", OFS_KEY0, 32'h1);
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_KSEL, 32'h1);
    kchk("lock_survives", '0);
    wr(OFS_KSEL, 32'h0);
    kchk("root_survives", rk);
    wr(OFS_ENABLE, 32'h0);
    kchk("disabled_key", '0);
    // power-on reset, secure state makes key words write-once
    do_reset(1'b1);
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_LCS, 32'h2);
    rchk("lifecycle_secure", OFS_LCS, 32'h2);
    pchk("lifecycle_port", {125'h0, lifecycle_state}, {125'h0, LCS_SECURE});
    wr(OFS_KEY2, 32'h13572468);
    wr(OFS_KEY2, 32'hFFFFFFFF);
    kchk("write_once", {32'h0, 32'h13572468, 64'h0});
    rchk("status_one_word", OFS_KEY0, 32'h0);
    wr(OFS_KSEL, 32'h1);
    kchk("lock_cleared", FK);
    wrap_up();
  end
endmodule
